// ===== frlo_synth_ctrl.sv
// apb register file, vco and band choice, charge pump choice and modulator drive
`timescale 1ns/1ps
module frlo_synth_ctrl #(
   parameter int MOD_DIV = frlo_pkg::MOD_DIV_DEF // pclk cycles per modulator step
) (
   input  wire logic                          pclk,           // 20 MHz clock
   input  wire logic                          presetn,        // async reset, active low
   input  wire logic [frlo_pkg::ADDR_W-1:0]   paddr,          // apb byte address
   input  wire logic                          psel,           // apb select
   input  wire logic                          penable,        // apb enable
   input  wire logic                          pwrite,         // apb direction
   input  wire logic [31:0]                   pwdata,         // apb write data
   output logic      [31:0]                   prdata,         // apb read data
   output logic                               pready,         // apb ready
   output logic                               pslverr,        // apb error, unmapped
   input  wire logic [1:0]                    tune_vrange_in, // tuning voltage range pin
   input  wire logic                          lock_detect_in, // analog lock detector pin
   output logic      [3:0]                    vco_choice,     // vco index*2 + band
   output logic      [1:0]                    cp_current,     // charge pump level
   output logic      [frlo_pkg::RATIO_W-1:0]  div_ratio,      // instantaneous divide ratio
   output logic                               lo_output_div_select,  // lo output divider
   output logic                               reference_div_select,  // reference halving off
   output logic      [2:0]                    baseband_atten2_code,  // second attenuator
   output logic      [2:0]                    baseband_atten1_code,  // first attenuator
   output logic      [3:0]                    baseband_amp_gain_code // baseband amplifier
);
   import frlo_pkg::*;
   if (MOD_DIV < 1) begin : g_chk
      $error("MOD_DIV must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////////////
   logic [7:0] refdiv_reg, dsm_reg, cplvl_reg, lodiv_reg, amp_reg, atten_reg, vcosel_reg;
   logic [7:0] div0_reg, div1_reg, div2_reg, div3_reg;
   logic       pready_reg, pslverr_reg, start_reg;
   logic [31:0] prdata_reg;
   wire  [7:0] idx     = paddr[9:2];
   wire        aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
   wire  sel_refdiv = aligned && idx == IDX_REFDIV;
   wire  sel_dsm    = aligned && idx == IDX_DSM;
   wire  sel_cplvl  = aligned && idx == IDX_CPLVL;
   wire  sel_lodiv  = aligned && idx == IDX_LODIV;
   wire  sel_div0   = aligned && idx == IDX_DIV0;
   wire  sel_div1   = aligned && idx == IDX_DIV1;
   wire  sel_div2   = aligned && idx == IDX_DIV2;
   wire  sel_div3   = aligned && idx == IDX_DIV3;
   wire  sel_amp    = aligned && idx == IDX_AMP;
   wire  sel_atten  = aligned && idx == IDX_ATTEN;
   wire  sel_vcosel = aligned && idx == IDX_VCOSEL;
   wire  sel_status = aligned && idx == IDX_STATUS;
   wire  mapped = sel_refdiv | sel_dsm | sel_cplvl | sel_lodiv | sel_div0 | sel_div1
                | sel_div2 | sel_div3 | sel_amp | sel_atten | sel_vcosel | sel_status;
   // one wait state: ready is raised on the first access edge, the transfer ends on the next
   wire  acc_first = psel && penable && !pready_reg;
   wire  xfer      = psel && penable && pready_reg;
   wire  wr        = xfer && pwrite && mapped;
   wire  [7:0] wb  = pwdata[7:0];
   wire  start_next = wr && sel_div3 && wb[START_BIT];
   // tuning state and status byte
   frlo_tune_type state_reg;
   logic [3:0] choice_reg;
   logic [1:0] cp_reg;
   logic       lock_flag_reg;
   wire  [INT_W-1:0]  int_word  = {div0_reg, div1_reg[7]};
   wire  [FRAC_W-1:0] frac_word = {div1_reg[6:0], div2_reg, div3_reg[7:5]};
   wire  word_invalid = int_word < INT_MIN;
   wire  [7:0] status = {word_invalid, cp_reg, choice_reg, lock_flag_reg};
   wire  [7:0] rbyte =
      sel_refdiv ? refdiv_reg : sel_dsm ? dsm_reg : sel_cplvl ? cplvl_reg :
      sel_lodiv  ? lodiv_reg  : sel_div0 ? div0_reg : sel_div1 ? div1_reg :
      sel_div2   ? div2_reg   : sel_div3 ? {div3_reg[7:5], 5'b00000} :
      sel_amp    ? amp_reg    : sel_atten ? atten_reg : sel_vcosel ? vcosel_reg :
      sel_status ? status : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= acc_first;
         pslverr_reg <= acc_first && !mapped;
         prdata_reg  <= (acc_first && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {refdiv_reg, dsm_reg, cplvl_reg, lodiv_reg} <= {4{REG_RST}};
         {div0_reg, div1_reg, div2_reg, div3_reg}    <= {4{REG_RST}};
         {amp_reg, atten_reg}                        <= {2{REG_RST}};
         vcosel_reg                                  <= VCOSEL_RST;
         start_reg                                   <= 1'b0;
      end else begin
         if (wr && sel_refdiv) refdiv_reg <= wb;
         if (wr && sel_dsm)    dsm_reg    <= wb;
         if (wr && sel_cplvl)  cplvl_reg  <= wb;
         if (wr && sel_lodiv)  lodiv_reg  <= wb;
         if (wr && sel_div0)   div0_reg   <= wb;
         if (wr && sel_div1)   div1_reg   <= wb;
         if (wr && sel_div2)   div2_reg   <= wb;
         if (wr && sel_div3)   div3_reg   <= wb;
         if (wr && sel_amp)    amp_reg    <= wb;
         if (wr && sel_atten)  atten_reg  <= wb;
         if (wr && sel_vcosel) vcosel_reg <= wb;
         start_reg <= start_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // pin inputs pass two flops before use
   logic [1:0] vr_meta_reg, vr_reg;
   logic       lk_meta_reg, lk_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {vr_meta_reg, vr_reg, lk_meta_reg, lk_reg} <= 6'h00;
      end else begin
         vr_meta_reg <= tune_vrange_in;
         vr_reg      <= vr_meta_reg;
         lk_meta_reg <= lock_detect_in;
         lk_reg      <= lk_meta_reg;
      end
   end

   localparam int CNT_W = $clog2(SETTLE_CYC + 1);
   logic [CNT_W-1:0] cnt_reg;
   wire  manual     = vcosel_reg[MAN_EN_BIT];
   wire  [3:0] man_choice = (vcosel_reg[3:0] < 4'(NUM_CHOICES)) ? vcosel_reg[3:0]
                          : 4'(NUM_CHOICES - 1);
   wire  settled    = cnt_reg == CNT_W'(SETTLE_CYC - 1);
   // auto sweep climbs while the tuning voltage sits in its top range
   wire  climb      = !manual && vr_reg == 2'b11 && choice_reg < 4'(NUM_CHOICES - 1);
   wire  [1:0] cp_pick = cplvl_reg[7 - 2 * vr_reg -: 2];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= TS_IDLE;
         cnt_reg       <= '0;
         choice_reg    <= 4'h0;
         cp_reg        <= 2'b00;
         lock_flag_reg <= 1'b0;
      end else if (start_reg) begin
         state_reg     <= TS_SETTLE;
         cnt_reg       <= '0;
         choice_reg    <= manual ? man_choice : 4'h0;
         lock_flag_reg <= 1'b0;
      end else begin
         case (state_reg)
            TS_IDLE: begin
               lock_flag_reg <= 1'b0;
            end
            TS_SETTLE: begin
               cnt_reg <= settled ? '0 : cnt_reg + 1'b1;
               if (settled && climb) begin
                  choice_reg <= choice_reg + 4'h1;
               end else if (settled) begin
                  state_reg <= TS_LOCKWAIT;
               end
            end
            TS_LOCKWAIT: begin
               if (lk_reg) begin
                  state_reg     <= TS_LOCKED;
                  cp_reg        <= cp_pick;
                  lock_flag_reg <= 1'b1;
               end
            end
            TS_LOCKED: begin
               if (!lk_reg) begin
                  state_reg     <= TS_LOCKWAIT;
                  lock_flag_reg <= 1'b0;
               end
            end
            default: state_reg <= TS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // modulator steps at the reference rate, an enable from a divider
   localparam int DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
   logic [DIV_W-1:0] div_cnt_reg;
   logic             step_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= '0;
         step_reg    <= 1'b0;
      end else begin
         step_reg    <= div_cnt_reg == DIV_W'(MOD_DIV - 1);
         div_cnt_reg <= (div_cnt_reg == DIV_W'(MOD_DIV - 1)) ? '0 : div_cnt_reg + 1'b1;
      end
   end

   frlo_sdm_if sdm_bus ();
   assign sdm_bus.int_word  = int_word;
   assign sdm_bus.frac_word = frac_word;
   assign sdm_bus.bypass    = dsm_reg[DSM_BIT];
   assign sdm_bus.step      = step_reg;
   assign sdm_bus.load      = start_reg;
   frlo_sdm u_sdm (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (sdm_bus.sdm)
   );

   assign prdata                 = prdata_reg;
   assign pready                 = pready_reg;
   assign pslverr                = pslverr_reg;
   assign vco_choice             = choice_reg;
   assign cp_current             = cp_reg;
   assign div_ratio              = sdm_bus.ratio;
   assign lo_output_div_select   = lodiv_reg[LODIV_BIT];
   assign reference_div_select   = refdiv_reg[REFDIV_BIT];
   assign baseband_atten2_code   = atten_reg[5:3];
   assign baseband_atten1_code   = atten_reg[2:0];
   assign baseband_amp_gain_code = amp_reg[3:0];

   ////////////////////////////////////////////////////////////////////////////////////
   sequence s_start_write;
      psel && penable && pready && pwrite && sel_div3 && pwdata[START_BIT];
   endsequence
   sequence s_settle_begins;
      ##1 start_reg ##1 state_reg == TS_SETTLE && cnt_reg == '0;
   endsequence
   property p_start_tunes;
      @(posedge pclk) disable iff (!presetn) s_start_write |-> s_settle_begins;
   endproperty
   a_start_tunes: assert property (p_start_tunes) else $error("start write ignored");
   property p_lock_flag;
      @(posedge pclk) disable iff (!presetn)
      state_reg == TS_LOCKWAIT && lk_reg && !start_reg |=> lock_flag_reg && state_reg == TS_LOCKED;
   endproperty
   a_lock_flag: assert property (p_lock_flag) else $error("lock not reported");
   property p_lock_only_locked;
      @(posedge pclk) disable iff (!presetn) lock_flag_reg |-> state_reg == TS_LOCKED;
   endproperty
   a_lock_only_locked: assert property (p_lock_only_locked) else $error("stray lock");
   property p_manual_hold;
      @(posedge pclk) disable iff (!presetn)
      state_reg == TS_SETTLE && manual && !start_reg |=> $stable(choice_reg);
   endproperty
   a_manual_hold: assert property (p_manual_hold) else $error("manual choice moved");
   property p_choice_range;
      @(posedge pclk) disable iff (!presetn) choice_reg < 4'(NUM_CHOICES);
   endproperty
   a_choice_range: assert property (p_choice_range) else $error("choice beyond twelve");
   property p_cp_apply;
      @(posedge pclk) disable iff (!presetn)
      state_reg == TS_LOCKWAIT && lk_reg && !start_reg |=> cp_current == $past(cp_pick);
   endproperty
   a_cp_apply: assert property (p_cp_apply) else $error("pump level not applied");
   property p_apb_wait;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing");
endmodule : frlo_synth_ctrl

// ===== frlo_pkg.sv
// constants, register map and types shared by the synthesizer control block
package frlo_pkg;
   localparam int       ADDR_W      = 12;
   localparam int       INT_W       = 9;
   localparam int       FRAC_W      = 18;
   localparam int       RATIO_W     = 10;
   localparam int       NUM_CHOICES = 12;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_REFDIV = 8'h02;
   localparam logic [7:0] IDX_DSM    = 8'h10;
   localparam logic [7:0] IDX_CPLVL  = 8'h11;
   localparam logic [7:0] IDX_LODIV  = 8'h18;
   localparam logic [7:0] IDX_DIV0   = 8'h19;
   localparam logic [7:0] IDX_DIV1   = 8'h1A;
   localparam logic [7:0] IDX_DIV2   = 8'h1B;
   localparam logic [7:0] IDX_DIV3   = 8'h1C;
   localparam logic [7:0] IDX_AMP    = 8'h1D;
   localparam logic [7:0] IDX_ATTEN  = 8'h1F;
   localparam logic [7:0] IDX_VCOSEL = 8'h30;
   localparam logic [7:0] IDX_STATUS = 8'h31;
   // field positions
   localparam int       REFDIV_BIT  = 1;
   localparam int       DSM_BIT     = 6;
   localparam int       LODIV_BIT   = 6;
   localparam int       START_BIT   = 4;
   localparam int       MAN_EN_BIT  = 4;
   // reset values
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [7:0] VCOSEL_RST = 8'h00;
   // divider arithmetic
   localparam logic [RATIO_W-1:0] INT_OFFSET = 10'h020;
   localparam logic [INT_W-1:0]   INT_MIN    = 9'h006;
   // timing
   localparam int       CLK_NS      = 50;
   localparam int       SETTLE_NS   = 2000;
   localparam int       SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int       MOD_DIV_DEF = 2;
   typedef enum logic [1:0] {TS_IDLE, TS_SETTLE, TS_LOCKWAIT, TS_LOCKED} frlo_tune_type;
endpackage : frlo_pkg

// ===== frlo_sdm_if.sv
// carrier between the tuning control and the sigma-delta modulator
`timescale 1ns/1ps
interface frlo_sdm_if;
   import frlo_pkg::*;
   logic [INT_W-1:0]   int_word;
   logic [FRAC_W-1:0]  frac_word;
   logic               bypass;
   logic               step;
   logic               load;
   logic [RATIO_W-1:0] ratio;
   modport ctrl (output int_word, frac_word, bypass, step, load, input ratio);
   modport sdm  (input int_word, frac_word, bypass, step, load, output ratio);
endinterface : frlo_sdm_if

// ===== frlo_sdm.sv
// third-order mash sigma-delta modulator producing the instantaneous divide ratio
`timescale 1ns/1ps
module frlo_sdm (
   input  wire logic  pclk,    // system clock
   input  wire logic  presetn, // async reset, active low
   frlo_sdm_if.sdm    bus      // words in, ratio out
);
   import frlo_pkg::*;
   logic [FRAC_W-1:0]  acc1_reg, acc2_reg, acc3_reg;
   logic               c2d_reg, c3d_reg, c3dd_reg;
   logic [RATIO_W-1:0] ratio_reg;
   wire  [FRAC_W:0]    sum1 = {1'b0, acc1_reg} + {1'b0, bus.frac_word};
   wire  [FRAC_W:0]    sum2 = {1'b0, acc2_reg} + {1'b0, sum1[FRAC_W-1:0]};
   wire  [FRAC_W:0]    sum3 = {1'b0, acc3_reg} + {1'b0, sum2[FRAC_W-1:0]};
   wire  c1 = sum1[FRAC_W];
   wire  c2 = sum2[FRAC_W];
   wire  c3 = sum3[FRAC_W];
   // eight output levels, -3 .. +4
   wire  signed [3:0]  dither = $signed({3'b000, c1}) + $signed({3'b000, c2})
                              - $signed({3'b000, c2d_reg}) + $signed({3'b000, c3})
                              - $signed({2'b00, c3d_reg, 1'b0}) + $signed({3'b000, c3dd_reg});
   wire  [RATIO_W-1:0] base = {1'b0, bus.int_word} + INT_OFFSET;
   wire  [RATIO_W-1:0] ratio_next = bus.bypass ? base
                                  : base + {{(RATIO_W-4){dither[3]}}, dither};
   assign bus.ratio = ratio_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {acc1_reg, acc2_reg, acc3_reg} <= '0;
         {c2d_reg, c3d_reg, c3dd_reg}   <= 3'b000;
         ratio_reg                      <= '0;
      end else if (bus.load) begin
         {acc1_reg, acc2_reg, acc3_reg} <= '0;
         {c2d_reg, c3d_reg, c3dd_reg}   <= 3'b000;
      end else if (bus.step) begin
         acc1_reg  <= sum1[FRAC_W-1:0];
         acc2_reg  <= sum2[FRAC_W-1:0];
         acc3_reg  <= sum3[FRAC_W-1:0];
         c2d_reg   <= c2;
         c3d_reg   <= c3;
         c3dd_reg  <= c3d_reg;
         ratio_reg <= ratio_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   property p_bypass_integer;
      @(posedge pclk) disable iff (!presetn)
      bus.step && !bus.load && bus.bypass |=> bus.ratio == $past(base);
   endproperty
   a_bypass_integer: assert property (p_bypass_integer) else $error("bypass dithered");
   property p_eight_levels;
      @(posedge pclk) disable iff (!presetn)
      bus.step && !bus.load |=> (bus.ratio + 10'h003 >= $past(base))
                                && (bus.ratio <= $past(base) + 10'h004);
   endproperty
   a_eight_levels: assert property (p_eight_levels) else $error("ratio outside 8 levels");
   property p_zero_frac_flat;
      @(posedge pclk) disable iff (!presetn)
      bus.load ##1 (bus.frac_word == '0 && bus.step && !bus.load) |=> bus.ratio == $past(base);
   endproperty
   a_zero_frac_flat: assert property (p_zero_frac_flat) else $error("flat ratio lost");
endmodule : frlo_sdm

// ===== frlo_tb.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module tb;
   import frlo_pkg::*;
   logic               pclk;
   logic               presetn;
   logic [ADDR_W-1:0]  paddr;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [1:0]         vrange;
   logic               lock_in;
   logic [3:0]         vco_choice;
   logic [1:0]         cp_current;
   logic [RATIO_W-1:0] div_ratio;
   logic               lo_sel;
   logic               ref_sel;
   logic [2:0]         att2;
   logic [2:0]         att1;
   logic [3:0]         amp;
   int                 num_errors;
   int                 check_count;
   int                 cycles;
   localparam int      XTAL_KHZ = 40000;
   frlo_synth_ctrl #(.MOD_DIV(1)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tune_vrange_in(vrange), .lock_detect_in(lock_in),
      .vco_choice(vco_choice), .cp_current(cp_current), .div_ratio(div_ratio),
      .lo_output_div_select(lo_sel), .reference_div_select(ref_sel),
      .baseband_atten2_code(att2), .baseband_atten1_code(att1),
      .baseband_amp_gain_code(amp));
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   // hang guard, tests need well under ten thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer; request held until pready seen at a rising edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= {24'h000000, d};
      psel    <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb({2'b00, idx, 2'b00}, 1'b1, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      logic        e;
      apb({2'b00, idx, 2'b00}, 1'b0, 8'h00, r, e);
      chk(r, {24'h000000, exp});
   endtask : rdc
   // most significant bytes first, start bit rides with the last byte
   task automatic set_div(input logic [8:0] iw, input logic [17:0] fw);
      wr(IDX_DIV0, iw[8:1]);
      wr(IDX_DIV1, {iw[0], fw[17:11]});
      wr(IDX_DIV2, fw[10:3]);
      wr(IDX_DIV3, {fw[2:0], 1'b1, 4'h0});
   endtask : set_div
   task automatic poll_lock(input logic [7:0] exp);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      do begin
         apb({2'b00, IDX_STATUS, 2'b00}, 1'b0, 8'h00, r, e);
         n++;
      end while (r[0] !== 1'b1 && n < 400);
      chk(r, {24'h000000, exp});
   endtask : poll_lock
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      rdc(IDX_STATUS, 8'h80);
      wr(IDX_ATTEN, 8'h1A);
      wr(IDX_AMP, 8'h03);
      wr(IDX_LODIV, 8'h40);
      wr(IDX_REFDIV, 8'h02);
      // the last write lands on the edge just passed
      @(negedge pclk);
      chk({att2, att1, amp}, {3'b011, 3'b010, 4'b0011});
      chk({lo_sel, ref_sel}, 2'b11);
      rdc(IDX_ATTEN, 8'h1A);
      apb(12'h009, 1'b1, 8'hFF, r, e);
      chk(e, 1'b1);
      apb(12'h3FC, 1'b0, 8'h00, r, e);
      chk(r, 32'h00000000);
      chk(e, 1'b1);
   endtask : t_regs
   task automatic t_manual;
      wr(IDX_CPLVL, 8'h1B);
      wr(IDX_VCOSEL, 8'h15);
      set_div(9'h064, 18'h10000);
      rdc(IDX_DIV3, 8'h00);
      repeat (200) @(posedge pclk);
      lock_in <= 1'b1;
      poll_lock(8'h6B);
      chk(vco_choice, 4'h5);
      chk(cp_current, 2'b11);
   endtask : t_manual
   task automatic t_auto;
      int n;
      lock_in <= 1'b0;
      wr(IDX_VCOSEL, 8'h00);
      set_div(9'h064, 18'h10000);
      n = 0;
      while (vco_choice !== 4'hB && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      repeat (100) @(posedge pclk);
      chk(vco_choice, 4'hB);
      lock_in <= 1'b1;
      poll_lock(8'h77);
      lock_in <= 1'b0;
      vrange  <= 2'd1;
      repeat (6) @(posedge pclk);
      rdc(IDX_STATUS, 8'h76);
      lock_in <= 1'b1;
      poll_lock(8'h37);
      chk(cp_current, 2'b01);
   endtask : t_auto
   // words from a wanted vco frequency in khz, reference select written 1 earlier
   // wanted points sit on or up to half a step above an integer ratio, so the fraction never goes negative
   task automatic t_freq(input int fvco);
      int          rem;
      int          half;
      int          lo;
      int          sum;
      int          bad;
      logic [8:0]  iw;
      logic [17:0] fw;
      logic        byp;
      half = XTAL_KHZ / 2;
      iw   = 9'((fvco + half) / XTAL_KHZ - 32);
      rem  = fvco - (int'(iw) + 32) * XTAL_KHZ;
      if (rem > half - 125 && rem < half + 125) rem = half - 125;
      fw   = 18'(((longint'(rem) << 18) + half) / XTAL_KHZ);
      byp  = rem < 250;
      wr(IDX_DSM, {1'b0, byp, 6'h00});
      set_div(iw, fw);
      repeat (10) @(posedge pclk);
      sum = 0;
      bad = 0;
      repeat (1024) @(negedge pclk) begin
         sum += div_ratio;
         if (div_ratio < 10'(iw + 29) || div_ratio > 10'(iw + 36)) bad++;
         if (byp && div_ratio !== 10'(iw + 32)) bad++;
      end
      // mash error stays bounded, so the sum lands within a few counts
      lo = (int'(iw) + 32) * 1024 + (byp ? 0 : int'(fw) >> 8);
      chk(bad, 0);
      chk(sum > lo - 8 && sum < lo + 8, 1'b1);
   endtask : t_freq
   task automatic t_ratio;
      t_freq(5280100);
      t_freq(5290000);
      t_freq(5299950);
      t_freq(5280000);
   endtask : t_ratio
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      paddr   = '0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      pwdata  = '0;
      vrange  = 2'd3;
      lock_in = 1'b0;
      num_errors  = 0;
      check_count = 0;
      cycles      = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_manual();
      t_auto();
      t_ratio();
      close_out();
   end
endmodule : tb
